/* File: gpio_board_model.sv */
// board side of the pins: drives input pins, pull-down on released pins
`timescale 1ns/100ps
`default_nettype none
module gpio_board_model (
   input wire logic [4:0] pin_out_in,
   input wire logic [4:0] pin_oe_in,
   input wire logic [4:0] board_oe_in,
   input wire logic [4:0] board_level_in,
   output logic [4:0] wire_level_out
);
   // board drives only pins the chip leaves released (pin_oe_in low), inputs and reserved codes alike
   always_comb begin
      for (int k = 0; k < 5; k++) begin
         if (pin_oe_in[k]) begin
            wire_level_out[k] = pin_out_in[k];
         end else if (board_oe_in[k]) begin
            wire_level_out[k] = board_level_in[k];
         end else begin
            wire_level_out[k] = 1'b0;
         end
      end
   end
endmodule : gpio_board_model
`default_nettype wire

/* File: gpio_function_select_mux.sv */
// per-pin function multiplexer with axi4-lite register access and interrupt status
//
// Functional notes
// [RQ1] software sets each pin's direction bit to match its chosen function
// [RQ2] code 00h carries alternate audio lines: pin 0 first-if frame clock, others third-if
// [RQ3] code 01h as output drives the pin from its level bit
// [RQ4] code 01h as input: pin level readable back, edges raise events
// [RQ5] code 03h drives the interrupt request level onto the pin
// [RQ6] code 04h drives temperature shutdown state, 1 above the limit
// [RQ7] code 05h gives one 31 us pulse per accessory detect event
// [RQ8] code 09h drives first locked loop lock status
// [RQ9] code 0Ah drives second locked loop lock status
// [RQ10] code 0Bh drives first rate converter lock status
// [RQ11] code 0Ch drives second rate converter lock status
// [RQ12] code 0Dh drives first audio interface compressor signal detect
// [RQ13] code 0Fh drives second audio interface compressor signal detect
// [RQ14] code 11h drives the core fifo error flag
// [RQ15] code 14h drives headphone dc servo complete status
// [RQ16] codes 15h and 16h route first and second loop clocks out
// [RQ17] reserved codes are not used by software; pin output stays low, undriven
// [RQ18] every pin selects its function independently
`timescale 1ns/100ps
`default_nettype none
`include "gpio_mux_defines.svh"

module gpio_function_select_mux #(
   parameter int PULSE_CYCLES = `GPM_PULSE_CYCLES
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [`GPM_ADDR_W-1:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [`GPM_ADDR_W-1:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   input wire logic [`GPM_PINS-1:0] pin_in,
   output logic [`GPM_PINS-1:0] pin_out,
   output logic [`GPM_PINS-1:0] pin_oe_out,
   input wire logic first_if_adc_frame_clock_in,
   input wire logic third_if_record_data_in,
   input wire logic third_if_frame_clock_in,
   input wire logic third_if_bit_clock_in,
   output logic third_if_playback_data_out,
   output logic third_if_frame_clock_out,
   output logic third_if_bit_clock_out,
   input wire logic irq_request_in,
   input wire logic temp_shutdown_in,
   input wire logic accessory_detect_in,
   input wire logic first_locked_loop_lock_in,
   input wire logic second_locked_loop_lock_in,
   input wire logic first_rate_converter_lock_in,
   input wire logic second_rate_converter_lock_in,
   input wire logic first_audio_interface_compressor_detect_in,
   input wire logic second_audio_interface_compressor_detect_in,
   input wire logic fifo_error_in,
   input wire logic servo_done_in,
   input wire logic first_locked_loop_clock_in,
   input wire logic second_locked_loop_clock_in,
   output logic irq_out
);

   localparam int N = `GPM_PINS;
   localparam int EV = `GPM_EVT_BITS;

   typedef struct packed {
      logic [N-1:0][4:0] pin_function_code;
      logic [N-1:0] pin_level_bit;
      logic [N-1:0] pin_direction_bit;
      logic [N-1:0] pin_prev;
      logic [EV-1:0] irq_status;
      logic [EV-1:0] irq_mask;
      logic [`GPM_PULSE_W-1:0] pulse_count;
      logic acc_pulse;
      logic [N-1:0] pin_drive;
      logic [N-1:0] pin_enable;
      logic [2:0] third_if_in;
      logic irq;
      logic aw_held;
      logic [`GPM_ADDR_W-1:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } state_t;

   state_t s;
   state_t next_s;
   logic rst_meta;
   logic rst_sync_n;

   ////////////////////////////////////////////////////////////////////////////////
   // reset release: asynchronous assert, two-flop synchronous release

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_meta <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   // byte-lane merge so partial writes leave the other lanes alone
   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction : merge

   // index of the pin config word, or N when the address is not a config word
   function automatic int cfg_index(input logic [`GPM_ADDR_W-1:0] a);
      int r;
      r = N;
      for (int i = 0; i < N; i++) begin
         if (a == `GPM_CFG_BASE + `GPM_ADDR_W'(4 * i)) begin
            r = i;
         end
      end
      return r;
   endfunction : cfg_index

   function automatic logic mapped(input logic [`GPM_ADDR_W-1:0] a);
      return (cfg_index(a) != N) || (a == `GPM_LEVELS_OFS) || (a == `GPM_STATUS_OFS) ||
             (a == `GPM_MASK_OFS);
   endfunction : mapped

   ////////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      logic [31:0] rd;
      logic [31:0] wr;
      logic [EV-1:0] events;
      logic [EV-1:0] clear;
      logic [N-1:0] alt_src;
      logic sel;
      int ci;
      rd = 32'h0000_0000;
      wr = 32'h0000_0000;
      events = '0;
      clear = '0;
      alt_src = {third_if_bit_clock_in, third_if_frame_clock_in, third_if_record_data_in, 1'b0,
                 first_if_adc_frame_clock_in};
      sel = 1'b0;
      ci = N;
      next_s = s;

      // write channel: address and data taken in either order
      if (s.awready && s_axi_awvalid_in) begin
         next_s.aw_held = 1'b1;
         next_s.aw_addr = s_axi_awaddr_in;
      end
      if (s.wready && s_axi_wvalid_in) begin
         next_s.w_held = 1'b1;
         next_s.w_data = s_axi_wdata_in;
         next_s.w_strb = s_axi_wstrb_in;
      end
      if (s.bvalid && s_axi_bready_in) begin
         next_s.bvalid = 1'b0;
      end

      if (s.aw_held && s.w_held && !s.bvalid) begin
         next_s.aw_held = 1'b0;
         next_s.w_held = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = mapped(s.aw_addr) ? `GPM_RESP_OKAY : `GPM_RESP_SLVERR;
         ci = cfg_index(s.aw_addr);
         if (ci != N) begin
            wr = merge({16'h0000, s.pin_direction_bit[ci], 8'h00, s.pin_level_bit[ci], 1'b0,
                        s.pin_function_code[ci]}, s.w_data, s.w_strb);
            next_s.pin_function_code[ci] = wr[`GPM_FN_HI:`GPM_FN_LO];
            next_s.pin_level_bit[ci] = wr[`GPM_LVL_BIT];
            next_s.pin_direction_bit[ci] = wr[`GPM_DIR_BIT]; // [RQ1]
         end
         if (s.aw_addr == `GPM_MASK_OFS) begin
            wr = merge({26'h0000000, s.irq_mask}, s.w_data, s.w_strb);
            next_s.irq_mask = wr[EV-1:0];
         end
         if (s.aw_addr == `GPM_STATUS_OFS) begin
            wr = merge(32'h0000_0000, s.w_data, s.w_strb);
            clear = wr[EV-1:0];
         end
      end
      next_s.awready = !next_s.aw_held && !next_s.bvalid;
      next_s.wready = !next_s.w_held && !next_s.bvalid;

      // read channel: one read at a time, data one cycle after the address
      if (s.rvalid && s_axi_rready_in) begin
         next_s.rvalid = 1'b0;
      end
      if (s.arready && s_axi_arvalid_in) begin
         ci = cfg_index(s_axi_araddr_in);
         if (ci != N) begin
            // input pins read back the pin, outputs read back the stored level
            rd = {16'h0000, s.pin_direction_bit[ci], 8'h00,
                  s.pin_direction_bit[ci] ? s.pin_prev[ci] : s.pin_level_bit[ci], 1'b0,
                  s.pin_function_code[ci]}; // [RQ4]
         end else if (s_axi_araddr_in == `GPM_LEVELS_OFS) begin
            rd = {27'h0000000, s.pin_prev}; // [RQ4]
         end else if (s_axi_araddr_in == `GPM_STATUS_OFS) begin
            rd = {26'h0000000, s.irq_status};
         end else if (s_axi_araddr_in == `GPM_MASK_OFS) begin
            rd = {26'h0000000, s.irq_mask};
         end
         next_s.rdata = rd;
         next_s.rresp = mapped(s_axi_araddr_in) ? `GPM_RESP_OKAY : `GPM_RESP_SLVERR;
         next_s.rvalid = 1'b1;
      end
      next_s.arready = !next_s.rvalid;

      // events: edges on logic-level input pins and the accessory detect strobe
      next_s.pin_prev = pin_in;
      for (int i = 0; i < N; i++) begin
         events[i] = s.pin_direction_bit[i] && (s.pin_function_code[i] == gpio_mux_pkg::FN_LOGIC)
                     && (pin_in[i] != s.pin_prev[i]); // [RQ4]
      end
      events[`GPM_EVT_ACC] = accessory_detect_in;
      // a set arriving with its clear wins
      next_s.irq_status = (s.irq_status & ~clear) | events;
      next_s.irq = |(next_s.irq_status & next_s.irq_mask);

      // one pulse per detect; a new detect restarts the full width
      if (accessory_detect_in) begin
         next_s.acc_pulse = 1'b1;
         next_s.pulse_count = `GPM_PULSE_W'(PULSE_CYCLES - 1); // [RQ7]
      end else if (s.pulse_count != '0) begin
         next_s.pulse_count = s.pulse_count - `GPM_PULSE_W'(1);
      end else begin
         next_s.acc_pulse = 1'b0; // [RQ7]
      end

      // per-pin selection, each pin on its own code
      for (int i = 0; i < N; i++) begin // [RQ18]
         case (s.pin_function_code[i])
            gpio_mux_pkg::FN_ALT_AUDIO: sel = alt_src[i]; // [RQ2]
            gpio_mux_pkg::FN_LOGIC: sel = s.pin_level_bit[i]; // [RQ3]
            gpio_mux_pkg::FN_IRQ: sel = irq_request_in | s.irq; // [RQ5]
            gpio_mux_pkg::FN_TEMP_SHUTDOWN: sel = temp_shutdown_in; // [RQ6]
            gpio_mux_pkg::FN_ACC_DETECT: sel = next_s.acc_pulse; // [RQ7]
            gpio_mux_pkg::FN_LOOP1_LOCK: sel = first_locked_loop_lock_in; // [RQ8]
            gpio_mux_pkg::FN_LOOP2_LOCK: sel = second_locked_loop_lock_in; // [RQ9]
            gpio_mux_pkg::FN_CONV1_LOCK: sel = first_rate_converter_lock_in; // [RQ10]
            gpio_mux_pkg::FN_CONV2_LOCK: sel = second_rate_converter_lock_in; // [RQ11]
            gpio_mux_pkg::FN_COMP1_DETECT: sel = first_audio_interface_compressor_detect_in; // [RQ12]
            gpio_mux_pkg::FN_COMP2_DETECT: sel = second_audio_interface_compressor_detect_in; // [RQ13]
            gpio_mux_pkg::FN_FIFO_ERROR: sel = fifo_error_in; // [RQ14]
            gpio_mux_pkg::FN_SERVO_DONE: sel = servo_done_in; // [RQ15]
            // loop clocks are resampled here, so only loop clocks well below clk_in survive
            gpio_mux_pkg::FN_LOOP1_CLOCK: sel = first_locked_loop_clock_in; // [RQ16]
            gpio_mux_pkg::FN_LOOP2_CLOCK: sel = second_locked_loop_clock_in; // [RQ16]
            default: sel = 1'b0; // [RQ17]
         endcase
         next_s.pin_drive[i] = sel;
         // inputs and reserved codes leave the pin released
         next_s.pin_enable[i] = !s.pin_direction_bit[i] &&
                                mapped_fn(s.pin_function_code[i]); // [RQ17]
      end

      // third interface lines sampled from pins set as inputs
      next_s.third_if_in = {pin_in[4], pin_in[3], pin_in[1]} &
                           {s.pin_direction_bit[4], s.pin_direction_bit[3],
                            s.pin_direction_bit[1]}; // [RQ2]
   end

   function automatic logic mapped_fn(input logic [4:0] f);
      logic r;
      r = 1'b0;
      case (f)
         gpio_mux_pkg::FN_ALT_AUDIO, gpio_mux_pkg::FN_LOGIC, gpio_mux_pkg::FN_IRQ,
         gpio_mux_pkg::FN_TEMP_SHUTDOWN, gpio_mux_pkg::FN_ACC_DETECT,
         gpio_mux_pkg::FN_LOOP1_LOCK, gpio_mux_pkg::FN_LOOP2_LOCK,
         gpio_mux_pkg::FN_CONV1_LOCK, gpio_mux_pkg::FN_CONV2_LOCK,
         gpio_mux_pkg::FN_COMP1_DETECT, gpio_mux_pkg::FN_COMP2_DETECT,
         gpio_mux_pkg::FN_FIFO_ERROR, gpio_mux_pkg::FN_SERVO_DONE,
         gpio_mux_pkg::FN_LOOP1_CLOCK, gpio_mux_pkg::FN_LOOP2_CLOCK: r = 1'b1;
         default: r = 1'b0;
      endcase
      return r;
   endfunction : mapped_fn

   ////////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge clk_in or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s <= '0;
         for (int i = 0; i < N; i++) begin
            s.pin_direction_bit[i] <= `GPM_DIR_RESET;
            s.pin_function_code[i] <= (i == 0) ? `GPM_FN_RESET_PIN0 : `GPM_FN_RESET_OTHER;
         end
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs, each straight from the state register

   assign s_axi_awready_out = s.awready;
   assign s_axi_wready_out = s.wready;
   assign s_axi_bvalid_out = s.bvalid;
   assign s_axi_bresp_out = s.bresp;
   assign s_axi_arready_out = s.arready;
   assign s_axi_rvalid_out = s.rvalid;
   assign s_axi_rresp_out = s.rresp;
   assign s_axi_rdata_out = s.rdata;
   assign pin_out = s.pin_drive;
   assign pin_oe_out = s.pin_enable;
   assign third_if_playback_data_out = s.third_if_in[0];
   assign third_if_frame_clock_out = s.third_if_in[1];
   assign third_if_bit_clock_out = s.third_if_in[2];
   assign irq_out = s.irq;

endmodule : gpio_function_select_mux
`default_nettype wire

/* File: gpio_function_select_mux_tb.sv */
// self-checking bench for the pin function mux
`timescale 1ns/100ps
`default_nettype none
`include "gpio_mux_defines.svh"
`define CHK(what, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
   $display("unexpected %s: expected %0h seen %0h", what, e, g); end end
module gpio_function_select_mux_tb;
   localparam int PULSE = 20;
   localparam logic [4:0] codes [14] = '{5'h00, 5'h02, 5'h03, 5'h04, 5'h09, 5'h0A, 5'h0B,
      5'h0C, 5'h0D, 5'h0F, 5'h11, 5'h14, 5'h15, 5'h16};
   logic clk_in = 1'b0, rst_n_in = 1'b0, accessory_detect_in = 1'b0;
   logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
   logic [31:0] s_axi_wdata_in = 32'h00000000, s_axi_rdata_out, d;
   logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
   logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
   logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
   logic s_axi_rvalid_out, irq_out;
   logic [1:0] s_axi_bresp_out, s_axi_rresp_out, r;
   logic [4:0] pin_in, pin_out, pin_oe_out, board_oe = 5'h00, board_lvl = 5'h00;
   logic [15:0] srcv = 16'h0000;
   logic [2:0] tif;
   int mismatches = 0, n_compared = 0, cycles = 0;
   ////////////////////////////////////////////////////////////////////////////
   gpio_function_select_mux #(.PULSE_CYCLES(PULSE)) u_dut (.clk_in, .rst_n_in,
      .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in,
      .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
      .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
      .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
      .s_axi_rready_in, .pin_in, .pin_out, .pin_oe_out, .first_if_adc_frame_clock_in(srcv[0]),
      .third_if_record_data_in(srcv[1]), .third_if_frame_clock_in(srcv[2]),
      .third_if_bit_clock_in(srcv[3]), .third_if_playback_data_out(tif[0]),
      .third_if_frame_clock_out(tif[1]), .third_if_bit_clock_out(tif[2]),
      .irq_request_in(srcv[4]), .temp_shutdown_in(srcv[5]), .accessory_detect_in,
      .first_locked_loop_lock_in(srcv[6]), .second_locked_loop_lock_in(srcv[7]),
      .first_rate_converter_lock_in(srcv[8]), .second_rate_converter_lock_in(srcv[9]),
      .first_audio_interface_compressor_detect_in(srcv[10]),
      .second_audio_interface_compressor_detect_in(srcv[11]), .fifo_error_in(srcv[12]),
      .servo_done_in(srcv[13]), .first_locked_loop_clock_in(srcv[14]),
      .second_locked_loop_clock_in(srcv[15]), .irq_out);
   gpio_board_model u_board (.pin_out_in(pin_out), .pin_oe_in(pin_oe_out),
      .board_oe_in(board_oe), .board_level_in(board_lvl), .wire_level_out(pin_in));
   ////////////////////////////////////////////////////////////////////////////
   task automatic axw(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_in);
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= v;
      {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'b111;
      do begin
         @(posedge clk_in);
         if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
         if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      end while (!s_axi_bvalid_out);
      r = s_axi_bresp_out;
      s_axi_bready_in <= 1'b0;
   endtask : axw
   task automatic axr(input logic [7:0] a);
      @(posedge clk_in);
      s_axi_araddr_in <= a;
      {s_axi_arvalid_in, s_axi_rready_in} <= 2'b11;
      do begin
         @(posedge clk_in);
         if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
      end while (!s_axi_rvalid_out);
      d = s_axi_rdata_out;
      r = s_axi_rresp_out;
      s_axi_rready_in <= 1'b0;
   endtask : axr
   // output pins only: direction bit cleared together with the code
   task automatic cfg(input int k, input logic [4:0] c, input logic lvl);
      axw(8'(k * 4), {16'h0000, 9'h000, lvl, 1'b0, c});
      `CHK("bresp", 2'h0, r)
   endtask : cfg
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #4 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (8) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      for (int k = 0; k < 5; k++) begin
         axr(8'(k * 4));
         `CHK("cfg reset", (k == 0) ? 32'h00008000 : 32'h00008001, d)
      end
      axr(8'h20);
      `CHK("unmapped resp", 2'h2, r)
      `CHK("unmapped data", 32'h00000000, d)
      $display("test reset done");
      board_oe <= 5'h1E;
      board_lvl <= 5'h1E;
      repeat (3) @(posedge clk_in);
      axr(8'h08);
      `CHK("input level", 32'h00008041, d)
      `CHK("third if in", 3'h7, tif)
      axr(`GPM_STATUS_OFS);
      `CHK("edge status", 32'h0000001E, d)
      `CHK("irq masked", 1'b0, irq_out)
      axw(`GPM_MASK_OFS, 32'h0000001E);
      cfg(0, 5'h03, 1'b0);
      repeat (3) @(posedge clk_in);
      `CHK("irq", 1'b1, irq_out)
      `CHK("irq pin", 1'b1, pin_out[0])
      board_oe <= 5'h00;
      repeat (3) @(posedge clk_in);
      axw(`GPM_STATUS_OFS, 32'h0000001E);
      repeat (2) @(posedge clk_in);
      `CHK("irq cleared", 1'b0, irq_out)
      $display("test input and interrupt done");
      foreach (codes[i]) begin
         for (int k = 0; k < 5; k++) cfg(k, codes[i], 1'b0);
         for (int v = 1; v >= 0; v--) begin
            srcv <= {16{v[0]}};
            repeat (3) @(posedge clk_in);
            `CHK("pin oe", (codes[i] == 5'h02) ? 5'h00 : 5'h1F, pin_oe_out)
            `CHK("pin out", (v == 0 || codes[i] == 5'h02) ? 5'h00 : (codes[i] == 5'h00) ?
               5'h1D : 5'h1F, pin_out)
         end
      end
      $display("test function codes done");
      cfg(0, 5'h04, 1'b0);
      cfg(1, 5'h01, 1'b1);
      cfg(2, 5'h01, 1'b0);
      repeat (3) @(posedge clk_in);
      `CHK("mixed pins", 3'h2, pin_out[2:0])
      axw(`GPM_LEVELS_OFS, 32'h0000001F);
      axr(`GPM_LEVELS_OFS);
      `CHK("levels", 32'h00000002, d)
      $display("test mixed pins done");
      for (int k = 0; k < 5; k++) cfg(k, 5'h05, 1'b0);
      @(posedge clk_in);
      accessory_detect_in <= 1'b1;
      @(posedge clk_in);
      accessory_detect_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      `CHK("pulse high", 5'h1F, pin_out)
      repeat (PULSE) @(posedge clk_in);
      `CHK("pulse low", 5'h00, pin_out)
      axr(`GPM_STATUS_OFS);
      `CHK("detect status", 32'h00000020, d)
      $display("test detect pulse done");
      tally_and_finish();
   end
endmodule : gpio_function_select_mux_tb
bind gpio_function_select_mux gpio_mux_checker #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (.*);
`default_nettype wire

/* File: gpio_mux_checker.sv */
// concurrent checks on the pin function mux ports
`timescale 1ns/100ps
`default_nettype none
module gpio_mux_checker #(
   parameter int PULSE_CYCLES = 3875
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   input wire logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic s_axi_wvalid_in,
   input wire logic s_axi_wready_out,
   input wire logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [4:0] pin_out,
   input wire logic [4:0] pin_oe_out,
   input wire logic first_if_adc_frame_clock_in,
   input wire logic third_if_record_data_in,
   input wire logic third_if_frame_clock_in,
   input wire logic third_if_bit_clock_in,
   input wire logic irq_request_in,
   input wire logic irq_out,
   input wire logic temp_shutdown_in,
   input wire logic accessory_detect_in,
   input wire logic first_locked_loop_lock_in,
   input wire logic second_locked_loop_lock_in,
   input wire logic first_rate_converter_lock_in,
   input wire logic second_rate_converter_lock_in,
   input wire logic first_audio_interface_compressor_detect_in,
   input wire logic second_audio_interface_compressor_detect_in,
   input wire logic fifo_error_in,
   input wire logic servo_done_in,
   input wire logic first_locked_loop_clock_in,
   input wire logic second_locked_loop_clock_in
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   ////////////////////////////////////////////////////////////////////////////
   logic [4:0] fn_s [5];
   logic [4:0] dir_s, lvl_s, expv, alt;
   logic [7:0] wa;
   logic [31:0] wd;
   logic [1:0] quiet;
   logic [11:0] acc_cnt;
   logic ok;
   // shadow lags the design, so checks wait for a quiet bus
   assign ok = quiet == 2'h3;
   assign alt = {third_if_bit_clock_in, third_if_frame_clock_in, third_if_record_data_in,
      1'b0, first_if_adc_frame_clock_in};
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < 5; i++) fn_s[i] <= (i == 0) ? 5'h00 : 5'h01;
         dir_s <= 5'h1F;
         lvl_s <= 5'h00;
         quiet <= 2'h0;
         acc_cnt <= 12'h000;
      end else begin
         if (s_axi_awvalid_in && s_axi_awready_out) wa <= s_axi_awaddr_in;
         if (s_axi_wvalid_in && s_axi_wready_out) wd <= s_axi_wdata_in;
         quiet <= (s_axi_bvalid_out || s_axi_awvalid_in) ? 2'h0 : (ok ? quiet : quiet + 2'h1);
         if (s_axi_bvalid_out && s_axi_bready_in && wa < 8'h14) begin
            fn_s[wa[4:2]] <= wd[4:0];
            dir_s[wa[4:2]] <= wd[15];
            lvl_s[wa[4:2]] <= wd[6];
         end
         acc_cnt <= accessory_detect_in ? 12'(PULSE_CYCLES) :
            ((acc_cnt != 12'h000) ? acc_cnt - 12'h001 : acc_cnt);
      end
   end
   always_comb begin
      for (int k = 0; k < 5; k++) begin
         case (fn_s[k])
            5'h00: expv[k] = alt[k];
            5'h01: expv[k] = lvl_s[k];
            5'h03: expv[k] = irq_request_in | irq_out;
            5'h04: expv[k] = temp_shutdown_in;
            5'h09: expv[k] = first_locked_loop_lock_in;
            5'h0A: expv[k] = second_locked_loop_lock_in;
            5'h0B: expv[k] = first_rate_converter_lock_in;
            5'h0C: expv[k] = second_rate_converter_lock_in;
            5'h0D: expv[k] = first_audio_interface_compressor_detect_in;
            5'h0F: expv[k] = second_audio_interface_compressor_detect_in;
            5'h11: expv[k] = fifo_error_in;
            5'h14: expv[k] = servo_done_in;
            5'h15: expv[k] = first_locked_loop_clock_in;
            5'h16: expv[k] = second_locked_loop_clock_in;
            default: expv[k] = 1'b0;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   for (genvar k = 0; k < 5; k++) begin : g_pin
      property drv(hit);
         ok && !dir_s[k] && hit |-> pin_oe_out[k] && pin_out[k] == $past(expv[k]);
      endproperty
      alt_audio_a: assert property (drv(fn_s[k] == 5'h00)) else $error("alt audio pin");
      logic_out_a: assert property (drv(fn_s[k] == 5'h01)) else $error("level pin");
      input_mode_a: assert property (ok && dir_s[k] |-> !pin_oe_out[k]) else $error("input oe");
      irq_pin_a: assert property (drv(fn_s[k] == 5'h03)) else $error("irq pin");
      temp_pin_a: assert property (drv(fn_s[k] == 5'h04)) else $error("temp pin");
      acc_pulse_a: assert property (ok && !dir_s[k] && fn_s[k] == 5'h05 |->
         pin_out[k] == (acc_cnt != 12'h000)) else $error("detect pulse");
      lock_pin_a: assert property (drv(fn_s[k] inside {[5'h09:5'h0C]}))
         else $error("lock pin");
      detect_pin_a: assert property (drv(fn_s[k] inside {5'h0D, 5'h0F, 5'h11, 5'h14}))
         else $error("status pin");
      loop_clock_a: assert property (drv(fn_s[k] inside {5'h15, 5'h16})) else $error("clk pin");
      reserved_a: assert property (ok && !(fn_s[k] inside {[5'h00:5'h01], [5'h03:5'h05],
         [5'h09:5'h0D], 5'h0F, 5'h11, [5'h14:5'h16]}) |-> !pin_oe_out[k] && !pin_out[k])
         else $error("reserved pin");
   end
   cover property (irq_out);
   cover property (acc_cnt == 12'h001);
   cover property (ok && dir_s == 5'h00);
endmodule : gpio_mux_checker
`default_nettype wire

/* File: gpio_mux_defines.svh */
// offsets, field positions, reset values and timing counts of the pin function mux
`ifndef GPIO_MUX_DEFINES_SVH
`define GPIO_MUX_DEFINES_SVH
`define GPM_PINS 5
`define GPM_ADDR_W 8
`define GPM_CFG_BASE 8'h00
`define GPM_LEVELS_OFS 8'h14
`define GPM_STATUS_OFS 8'h18
`define GPM_MASK_OFS 8'h1C
`define GPM_FN_HI 4
`define GPM_FN_LO 0
`define GPM_LVL_BIT 6
`define GPM_DIR_BIT 15
`define GPM_DIR_RESET 1'b1
`define GPM_FN_RESET_PIN0 5'h00
`define GPM_FN_RESET_OTHER 5'h01
`define GPM_EVT_BITS 6
`define GPM_EVT_ACC 5
`define GPM_RESP_OKAY 2'h0
`define GPM_RESP_SLVERR 2'h2
`define GPM_CLK_PERIOD_PS 8000
`define GPM_PULSE_US 31
`define GPM_PULSE_CYCLES ((`GPM_PULSE_US * 1000000) / `GPM_CLK_PERIOD_PS)
`define GPM_PULSE_W 12
`endif

/* File: gpio_mux_pkg.sv */
// types shared by the pin function mux
`default_nettype none
package gpio_mux_pkg;
   typedef enum logic [4:0] {
      FN_ALT_AUDIO = 5'h00,
      FN_LOGIC = 5'h01,
      FN_IRQ = 5'h03,
      FN_TEMP_SHUTDOWN = 5'h04,
      FN_ACC_DETECT = 5'h05,
      FN_LOOP1_LOCK = 5'h09,
      FN_LOOP2_LOCK = 5'h0A,
      FN_CONV1_LOCK = 5'h0B,
      FN_CONV2_LOCK = 5'h0C,
      FN_COMP1_DETECT = 5'h0D,
      FN_COMP2_DETECT = 5'h0F,
      FN_FIFO_ERROR = 5'h11,
      FN_SERVO_DONE = 5'h14,
      FN_LOOP1_CLOCK = 5'h15,
      FN_LOOP2_CLOCK = 5'h16
   } pin_function_code_t;
endpackage : gpio_mux_pkg
`default_nettype wire
